// file: verilog/adc_result_pkg.sv
/*
 * Shared constants for the voltage result register bank: register byte
 * addresses, channel indices, reset value, sign position and span limit.
 * Assumes an 8-bit register address space served by the control port.
 */
package adc_result_pkg;

	// Channel indices into the per-channel arrays.
	localparam int CHANNELS = 3;
	localparam int BUS_CH = 0;
	localparam int BAT_CH = 1;
	localparam int SYS_CH = 2;

	// Byte addresses of the result registers, high byte then low byte.
	localparam logic [7:0] BUS_HI_ADDR = 8'h1B;
	localparam logic [7:0] BUS_LO_ADDR = 8'h1C;
	localparam logic [7:0] BAT_HI_ADDR = 8'h1D;
	localparam logic [7:0] BAT_LO_ADDR = 8'h1E;
	localparam logic [7:0] SYS_HI_ADDR = 8'h1F;
	localparam logic [7:0] SYS_LO_ADDR = 8'h20;

	// Address tables indexed by channel.
	localparam logic [7:0] HI_ADDR [CHANNELS] = '{
		BUS_HI_ADDR, BAT_HI_ADDR, SYS_HI_ADDR};
	localparam logic [7:0] LO_ADDR [CHANNELS] = '{
		BUS_LO_ADDR, BAT_LO_ADDR, SYS_LO_ADDR};

	// Every result byte resets to this value, and unmapped reads show it.
	localparam logic [7:0] RESULT_RESET = 8'h00;

	// Sign position in the 16-bit result and in its high byte.
	localparam int SIGN_BIT = 15;
	localparam int HI_SIGN_BIT = 7;

	// Upper end of the reported span, in millivolts (10 V).
	localparam logic signed [15:0] SPAN_MAX_MV = 16'sh2710;

endpackage

// file: verilog/result_channel.sv
/*
 * One voltage result channel: the 16-bit result, plus a shadow of the low
 * byte taken when the high byte is read, so a high-then-low read pair
 * returns halves of one conversion.
 * Assumes high and low reads never arrive in the same cycle.
 */
`timescale 1ns/1ps

module result_channel (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic clear_i,
	input wire logic load_i,
	input wire logic [15:0] value_i,
	input wire logic rd_hi_i,
	input wire logic rd_lo_i,
	output logic [15:0] result_o,
	output logic [7:0] lo_o,
	output logic held_o
);

	logic [15:0] result_q, result_d;
	logic [7:0] shadow_q, shadow_d;
	logic held_q, held_d;

	// Next state; the restore command beats both a load and a read.
	always_comb begin
		result_d = result_q;
		shadow_d = shadow_q;
		held_d = held_q;
		if (load_i) begin
			result_d = value_i;
		end
		// R10 pair coherence
		if (rd_hi_i) begin
			shadow_d = result_q[7:0];
			held_d = 1'b1;
		end else if (rd_lo_i) begin
			held_d = 1'b0;
		end
		// R7 restore clears
		if (clear_i) begin
			result_d = {2{adc_result_pkg::RESULT_RESET}};
			shadow_d = adc_result_pkg::RESULT_RESET;
			held_d = 1'b0;
		end
	end

	// R7 reset to zero
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			result_q <= {2{adc_result_pkg::RESULT_RESET}};
			shadow_q <= adc_result_pkg::RESULT_RESET;
			held_q <= 1'b0;
		end else begin
			result_q <= result_d;
			shadow_q <= shadow_d;
			held_q <= held_d;
		end
	end

	// A pending shadow hides later conversions from the low byte.
	assign lo_o = held_q ? shadow_q : result_q[7:0];
	assign result_o = result_q;
	assign held_o = held_q;

endmodule // result_channel

// file: verilog/adc_voltage_result_registers.sv
/*
 * Read-only result registers of the monitoring converter for the input bus,
 * battery and system rail voltages, read through the register read port of
 * the control interface.
 * Assumes the serial engine and the conversion engine run on clk_i and give
 * one-cycle read and load strobes; watchdog expiry is not wired here since
 * it leaves these registers alone.
 */
//
// Notes on behaviour
// R1 - Byte 0x1C reads the bus voltage low byte, 128 mV at bit 7 to 1 mV.
// R2 - Byte 0x1D reads the battery high byte, sign then 16384 to 256 mV.
// R3 - Byte 0x1E reads the battery low byte, 128 mV down to 1 mV.
// R4 - Byte 0x1F reads the system rail high byte, sign then 16384 to 256 mV.
// R5 - Byte 0x20 reads the system rail low byte, 128 mV down to 1 mV.
// R6 - Each 16-bit result is two's complement with bit 15 as the sign.
// R7 - All bytes are read-only, zero after reset and after the restore command.
// R8 - Results cover zero to ten volts, larger readings saturate at 10 V; readings below zero are stored unchanged.
// R9 - Byte 0x1B reads the bus voltage high byte, sign then 16384 to 256 mV.
// R10 - A high-then-low read pair returns both bytes of one conversion.
`timescale 1ns/1ps

module adc_voltage_result_registers (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic reg_rst_i,
	input wire logic conv_valid_i,
	input wire logic [15:0] conv_bus_i,
	input wire logic [15:0] conv_bat_i,
	input wire logic [15:0] conv_sys_i,
	input wire logic rd_en_i,
	input wire logic [7:0] rd_addr_i,
	output logic [7:0] rd_data_o,
	output logic rd_valid_o
);

	localparam int CH = adc_result_pkg::CHANNELS;

	logic [15:0] raw_w [CH];
	logic [15:0] clamp_w [CH];
	logic [15:0] result_w [CH];
	logic [7:0] res_hi_w [CH];
	logic [7:0] res_lo_w [CH];
	logic [7:0] lo_w [CH];
	logic [CH-1:0] held_w;
	logic [CH-1:0] rd_hi_w;
	logic [CH-1:0] rd_lo_w;
	logic [7:0] rd_data_q, rd_data_d;
	logic rd_valid_q, rd_valid_d;

	// Conversion inputs gathered by channel index.
	assign raw_w[adc_result_pkg::BUS_CH] = conv_bus_i;
	assign raw_w[adc_result_pkg::BAT_CH] = conv_bat_i;
	assign raw_w[adc_result_pkg::SYS_CH] = conv_sys_i;

	// One channel per measured voltage, with its address decode.
	for (genvar i = 0; i < CH; i++) begin : g_ch
		// R8 span saturation
		assign clamp_w[i] = ($signed(raw_w[i]) > adc_result_pkg::SPAN_MAX_MV)
			? adc_result_pkg::SPAN_MAX_MV : raw_w[i];
		// R6 sign kept whole
		// The clamp only lowers positive readings, so bit 15 always passes.
		assign res_hi_w[i] = result_w[i][15:8];
		assign res_lo_w[i] = result_w[i][7:0];
		assign rd_hi_w[i] = rd_en_i && (rd_addr_i == adc_result_pkg::HI_ADDR[i]);
		assign rd_lo_w[i] = rd_en_i && (rd_addr_i == adc_result_pkg::LO_ADDR[i]);

		result_channel u_chan (
			.clk_i(clk_i),
			.nrst_i(nrst_i),
			.clear_i(reg_rst_i),
			.load_i(conv_valid_i),
			.value_i(clamp_w[i]),
			.rd_hi_i(rd_hi_w[i]),
			.rd_lo_i(rd_lo_w[i]),
			.result_o(result_w[i]),
			.lo_o(lo_w[i]),
			.held_o(held_w[i])
		);
	end

	// Read mux; unmapped addresses read zero and nothing is writable.
	// There is no write path at all, so a host cannot disturb a result
	// that the conversion engine is about to replace.
	// R7 read-only bytes
	always_comb begin
		rd_valid_d = rd_en_i;
		rd_data_d = rd_data_q;
		if (rd_en_i) begin
			rd_data_d = adc_result_pkg::RESULT_RESET;
			for (int i = 0; i < CH; i++) begin
				// R1 R2 R3 R4 R5 R9 byte map
				if (rd_hi_w[i]) begin
					rd_data_d = res_hi_w[i];
				end
				if (rd_lo_w[i]) begin
					rd_data_d = lo_w[i];
				end
			end
		end
	end

	// Read data is registered, so it lands one cycle after the strobe.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rd_data_q <= adc_result_pkg::RESULT_RESET;
			rd_valid_q <= 1'b0;
		end else begin
			rd_data_q <= rd_data_d;
			rd_valid_q <= rd_valid_d;
		end
	end

	assign rd_data_o = rd_data_q;
	assign rd_valid_o = rd_valid_q;

	// Helper copies of each low byte at its last high-byte read. They are
	// read only by the checks below, and let a pair be followed across any
	// number of idle cycles without a long repetition in a property.
	logic [7:0] pair_lo_q [CH];
	logic [7:0] pair_lo_d [CH];

	// Next copy: taken on every high-byte read, a re-read included.
	always_comb begin
		for (int i = 0; i < CH; i++) begin
			pair_lo_d[i] = pair_lo_q[i];
			if (rd_hi_w[i]) begin
				pair_lo_d[i] = res_lo_w[i];
			end
		end
	end

	// Copy register; cleared with the rest of the bank on reset.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			for (int i = 0; i < CH; i++) begin
				pair_lo_q[i] <= adc_result_pkg::RESULT_RESET;
			end
		end else begin
			pair_lo_q <= pair_lo_d;
		end
	end

	// A whole cleared result, for the restore check.
	localparam logic [15:0] ZERO_RESULT = {2{adc_result_pkg::RESULT_RESET}};

	// Checks of the register map, the load path, the restore command and
	// the pair snapshot. Each read check compares the answer with what was
	// stored when the read was taken, so reads may come any time after a
	// load and still be checked.
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);

	bus_hi_map_a: assert property ( // R9
		rd_hi_w[adc_result_pkg::BUS_CH] && !reg_rst_i
		|=> rd_data_o == $past(res_hi_w[adc_result_pkg::BUS_CH]))
		else $error("bus high byte does not match stored result");

	bus_lo_map_a: assert property ( // R1
		rd_lo_w[adc_result_pkg::BUS_CH] && !held_w[adc_result_pkg::BUS_CH]
		&& !reg_rst_i
		|=> rd_data_o == $past(res_lo_w[adc_result_pkg::BUS_CH]))
		else $error("bus low byte does not match stored result");

	bat_hi_map_a: assert property ( // R2
		rd_hi_w[adc_result_pkg::BAT_CH] && !reg_rst_i
		|=> rd_data_o == $past(res_hi_w[adc_result_pkg::BAT_CH]))
		else $error("battery high byte does not match stored result");

	bat_lo_map_a: assert property ( // R3
		rd_lo_w[adc_result_pkg::BAT_CH] && !held_w[adc_result_pkg::BAT_CH]
		&& !reg_rst_i
		|=> rd_data_o == $past(res_lo_w[adc_result_pkg::BAT_CH]))
		else $error("battery low byte does not match stored result");

	sys_hi_map_a: assert property ( // R4
		rd_hi_w[adc_result_pkg::SYS_CH] && !reg_rst_i
		|=> rd_data_o == $past(res_hi_w[adc_result_pkg::SYS_CH]))
		else $error("system high byte does not match stored result");

	sys_lo_map_a: assert property ( // R5
		rd_lo_w[adc_result_pkg::SYS_CH] && !held_w[adc_result_pkg::SYS_CH]
		&& !reg_rst_i
		|=> rd_data_o == $past(res_lo_w[adc_result_pkg::SYS_CH]))
		else $error("system low byte does not match stored result");

	sign_bit_a: assert property ( // R6
		conv_valid_i && !reg_rst_i
		|=> result_w[adc_result_pkg::SYS_CH][adc_result_pkg::SIGN_BIT]
		== $past(conv_sys_i[adc_result_pkg::SIGN_BIT]))
		else $error("stored result lost its sign bit");

	restore_zero_a: assert property ( // R7
		reg_rst_i
		|=> (result_w[adc_result_pkg::BUS_CH] == ZERO_RESULT)
		&& (result_w[adc_result_pkg::BAT_CH] == ZERO_RESULT)
		&& (result_w[adc_result_pkg::SYS_CH] == ZERO_RESULT)
		&& (held_w == '0))
		else $error("result not zero after restore command");

	load_keep_a: assert property ( // R8
		conv_valid_i && !reg_rst_i
		&& ($signed(conv_bus_i) <= adc_result_pkg::SPAN_MAX_MV)
		|=> result_w[adc_result_pkg::BUS_CH] == $past(conv_bus_i))
		else $error("in-span bus reading not stored unchanged");

	span_limit_a: assert property ( // R8
		conv_valid_i && !reg_rst_i &&
		($signed(conv_bat_i) > adc_result_pkg::SPAN_MAX_MV)
		|=> result_w[adc_result_pkg::BAT_CH] == adc_result_pkg::SPAN_MAX_MV)
		else $error("over-range reading not saturated");

	pair_coherent_a: assert property ( // R10
		rd_lo_w[adc_result_pkg::BAT_CH] && held_w[adc_result_pkg::BAT_CH]
		&& !reg_rst_i
		|=> rd_data_o == $past(pair_lo_q[adc_result_pkg::BAT_CH])
		&& !held_w[adc_result_pkg::BAT_CH])
		else $error("low byte not from same conversion as high byte");

	// Main scenarios worth seeing in simulation.
	pair_read_c: cover property (
		rd_hi_w[adc_result_pkg::BUS_CH] ##1 conv_valid_i
		##1 rd_lo_w[adc_result_pkg::BUS_CH]);
	restore_c: cover property (conv_valid_i ##1 reg_rst_i ##1 rd_en_i);
	clamp_c: cover property (conv_valid_i &&
		($signed(conv_sys_i) > adc_result_pkg::SPAN_MAX_MV));
	unmapped_c: cover property (rd_en_i && (rd_hi_w == '0) && (rd_lo_w == '0));
	torn_pair_c: cover property (held_w[adc_result_pkg::BAT_CH]
		&& conv_valid_i);

endmodule // adc_voltage_result_registers

// file: test/conv_engine_model.sv
/*
 * Behavioural model of the conversion engine that feeds the result bank.
 * Assumes the bench asks for a conversion with a one-cycle go strobe.
 */
`timescale 1ns/1ps

module conv_engine_model (
	input wire logic clk_i,
	input wire logic go_i,
	input wire logic [15:0] bus_i,
	input wire logic [15:0] bat_i,
	input wire logic [15:0] sys_i,
	output logic valid_o,
	output logic [15:0] bus_o,
	output logic [15:0] bat_o,
	output logic [15:0] sys_o
);
	// Start quiet so the bank sees no load before the first request.
	initial begin
		valid_o = 1'b0;
		bus_o = 16'h0000;
		bat_o = 16'h0000;
		sys_o = 16'h0000;
	end

	// Data toggles outside the done pulse, so a stale value never passes.
	always @(posedge clk_i) begin
		valid_o <= go_i;
		bus_o <= go_i ? bus_i : ~bus_o;
		bat_o <= go_i ? bat_i : ~bat_o;
		sys_o <= go_i ? sys_i : ~sys_o;
	end
endmodule // conv_engine_model

// file: test/adc_voltage_result_registers_tb.sv
/*
 * Self-checking bench for the voltage result bank.
 * Assumes the conversion engine model sits on the load side.
 */
`timescale 1ns/1ps

module adc_voltage_result_registers_tb;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic reg_rst_i = 1'b0;
	logic go = 1'b0;
	logic rd_en_i = 1'b0;
	logic [7:0] rd_addr_i = 8'h00;
	logic [15:0] nv [3] = '{16'h0000, 16'h0000, 16'h0000};
	logic conv_valid_i;
	logic [15:0] conv_bus_i, conv_bat_i, conv_sys_i;
	logic [7:0] rd_data_o, exp_b, lo_old;
	logic rd_valid_o;
	logic [15:0] res [3];
	logic [7:0] exp_q [$];
	int num_errors = 0;
	int tests_run = 0;

	always #5 clk_i = ~clk_i;

	conv_engine_model conv_engine_model_inst (.clk_i(clk_i), .go_i(go),
		.bus_i(nv[0]), .bat_i(nv[1]), .sys_i(nv[2]), .valid_o(conv_valid_i),
		.bus_o(conv_bus_i), .bat_o(conv_bat_i), .sys_o(conv_sys_i));

	adc_voltage_result_registers adc_voltage_result_registers_inst (
		.clk_i(clk_i), .nrst_i(nrst_i), .reg_rst_i(reg_rst_i),
		.conv_valid_i(conv_valid_i), .conv_bus_i(conv_bus_i),
		.conv_bat_i(conv_bat_i), .conv_sys_i(conv_sys_i),
		.rd_en_i(rd_en_i), .rd_addr_i(rd_addr_i),
		.rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o));

	// Readings above the span are expected to pin at its top.
	function automatic logic [15:0] sat(input logic [15:0] v);
		return ($signed(v) > adc_result_pkg::SPAN_MAX_MV) ?
			adc_result_pkg::SPAN_MAX_MV : v;
	endfunction

	// One read strobe per edge; the answer is noted for the monitor.
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_i);
		rd_en_i <= 1'b1;
		rd_addr_i <= a;
		exp_q.push_back(e);
	endtask

	task automatic idle();
		@(posedge clk_i);
		rd_en_i <= 1'b0;
		go <= 1'b0;
		reg_rst_i <= 1'b0;
	endtask

	// Waits until the load has landed before any read is made.
	task automatic conv(input logic [15:0] b, t, s);
		@(posedge clk_i);
		rd_en_i <= 1'b0;
		go <= 1'b1;
		nv <= '{b, t, s};
		res = '{sat(b), sat(t), sat(s)};
		idle();
		@(posedge clk_i);
	endtask

	// High byte before low byte, as a host reads a pair.
	task automatic chk_all();
		for (int c = 0; c < 3; c++) begin
			rd(adc_result_pkg::HI_ADDR[c], res[c][15:8]);
			rd(adc_result_pkg::LO_ADDR[c], res[c][7:0]);
		end
		rd(8'h21, adc_result_pkg::RESULT_RESET);
		idle();
		repeat (3) @(posedge clk_i);
	endtask

	task automatic test_done();
		if (num_errors == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Each answer is compared with the oldest note, on a settled edge.
	always @(negedge clk_i) begin
		if (rd_valid_o === 1'b1) begin
			exp_b = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
			tests_run++;
			if (rd_data_o !== exp_b) begin
				num_errors++;
				$display("Error rd_data_o expected %h seen %h", exp_b, rd_data_o);
			end
		end
	end

	initial begin
		void'($urandom(32'h52A5));
		res = '{16'h0000, 16'h0000, 16'h0000};
		repeat (2) @(posedge clk_i);
		nrst_i <= 1'b1;
		chk_all();
		conv(16'h2710, 16'h2711, 16'h8000); chk_all();
		repeat (20) begin
			conv(16'($urandom()), 16'($urandom()), 16'($urandom()));
			chk_all();
		end
		// A load between the halves must not tear the pair.
		lo_old = res[1][7:0];
		rd(adc_result_pkg::BAT_HI_ADDR, res[1][15:8]);
		rd(adc_result_pkg::BUS_LO_ADDR, res[0][7:0]);
		rd(adc_result_pkg::SYS_LO_ADDR, res[2][7:0]);
		conv(16'($urandom()), 16'h1234, 16'($urandom()));
		rd(adc_result_pkg::BAT_LO_ADDR, lo_old);
		rd(adc_result_pkg::BAT_LO_ADDR, 8'h34);
		idle();
		@(posedge clk_i);
		reg_rst_i <= 1'b1;
		idle();
		res = '{16'h0000, 16'h0000, 16'h0000};
		chk_all();
		conv(16'($urandom()), 16'($urandom()), 16'($urandom()));
		@(posedge clk_i);
		nrst_i <= 1'b0;
		idle();
		nrst_i <= 1'b1;
		res = '{16'h0000, 16'h0000, 16'h0000};
		chk_all();
		repeat (10) if (exp_q.size() > 0) @(posedge clk_i);
		if (exp_q.size() != 0) begin
			num_errors++;
			$display("Error read answers expected 0 seen %0d", exp_q.size());
		end
		test_done();
	end
endmodule // adc_voltage_result_registers_tb
